// ===== verilog/lim_pkg.sv
// constants, field layouts and carrier types for the line input mixer control
// assumes one register clock and byte-wide register writes from the control port
// ==========================================
// Overview of operation
// - bit 7 routes pair three/four into A
// - bit 6 routes pair six-five into B
// - bits 5,3,1 enable A pins 1,3,5
// - bits 4,2,0 enable B pins 2,4,6
// - each mixer sums any two single-ended sources
// - differential source overrides single-ended selections
// - attenuation inert with only one source
// - level bit 7 enables line A attenuation
// - level bit 6 enables line B attenuation
// - line A gain code bits 5:3, POR 011
// - line B gain code at low field, bits 2:0, POR 011
package lim_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] LIM_ADDR_SRC = 8'h0d;
    localparam logic [7:0] LIM_ADDR_LVL = 8'h0e;
    localparam logic [7:0] LIM_SRC_RST = 8'h00;
    localparam logic [7:0] LIM_LVL_RST = 8'h1b;
    // ==========================================
    // field positions
    localparam int LIM_B_A_DIFF = 7;
    localparam int LIM_B_B_DIFF = 6;
    localparam int LIM_B_A_SE1 = 5;
    localparam int LIM_B_B_SE2 = 4;
    localparam int LIM_B_A_SE3 = 3;
    localparam int LIM_B_B_SE4 = 2;
    localparam int LIM_B_A_SE5 = 1;
    localparam int LIM_B_B_SE6 = 0;
    localparam int LIM_B_A_ATT = 7;
    localparam int LIM_B_B_ATT = 6;
    localparam int LIM_A_GAIN_LSB = 3;
    localparam int LIM_B_GAIN_LSB = 0;
    localparam int LIM_NUM_SE = 3;
    // ==========================================
    // gain selections, binary-coded toward the analog preamp
    typedef enum logic [2:0] {
        LIM_G_20DB = 3'h0,
        LIM_G_14DB = 3'h1,
        LIM_G_3DB = 3'h2,
        LIM_G_0DB = 3'h3,
        LIM_G_M3DB = 3'h4,
        LIM_G_M6DB = 3'h5
    } lim_gain_t;
    // switch controls for one line mixer
    typedef struct packed {
        logic diff_en;
        logic [2:0] se_en;
        logic atten_6db;
        lim_gain_t gain;
    } lim_mix_ctl_t;
endpackage

// ===== verilog/lim_line_mixer_ctl.sv
// line input mixer control registers and switch decode
// assumes register writes come on the register clock from the control-port decoder
`timescale 1ns/10ps
module lim_line_mixer_ctl (
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // register port
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // mixer controls
    output lim_pkg::lim_mix_ctl_t LINE_A_CTL_O,
    output lim_pkg::lim_mix_ctl_t LINE_B_CTL_O
);
    import lim_pkg::*;

    logic [7:0] src_q;
    logic [7:0] lvl_q;
    lim_mix_ctl_t a_d;
    lim_mix_ctl_t b_d;
    lim_mix_ctl_t a_q;
    lim_mix_ctl_t b_q;

    // ==========================================
    // decode helpers
    function automatic lim_gain_t gain_of(input logic [2:0] code);
        case (code)
            3'h0: gain_of = LIM_G_20DB;
            3'h1: gain_of = LIM_G_14DB;
            3'h2: gain_of = LIM_G_3DB;
            3'h3: gain_of = LIM_G_0DB;
            3'h4: gain_of = LIM_G_M3DB;
            default: gain_of = LIM_G_M6DB;
        endcase
    endfunction

    // diff wins, so single-ended switches open whenever it is set
    function automatic lim_mix_ctl_t mix_of(input logic diff, input logic [2:0] se,
                                            input logic att, input logic [2:0] code);
        logic two;
        two = 1'b0;
        mix_of.diff_en = diff;
        mix_of.se_en = diff ? 3'h0 : se;
        // three sources is beyond the documented pairings; treat it like two
        two = ~diff && ((se[0] & se[1]) | (se[0] & se[2]) | (se[1] & se[2]));
        mix_of.atten_6db = att & two;
        mix_of.gain = gain_of(code);
    endfunction

    // ==========================================
    // registers
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            src_q <= LIM_SRC_RST;
        end else if (CE_I && REG_WR_I && REG_ADDR_I == LIM_ADDR_SRC) begin
            src_q <= REG_WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            lvl_q <= LIM_LVL_RST;
        end else if (CE_I && REG_WR_I && REG_ADDR_I == LIM_ADDR_LVL) begin
            lvl_q <= REG_WDATA_I;
        end
    end

    always_comb begin
        case (REG_ADDR_I)
            LIM_ADDR_SRC: REG_RDATA_O = src_q;
            LIM_ADDR_LVL: REG_RDATA_O = lvl_q;
            default: REG_RDATA_O = 8'h00;
        endcase
    end

    // ==========================================
    // switch decode
    always_comb begin
        a_d = mix_of(src_q[LIM_B_A_DIFF],
                     {src_q[LIM_B_A_SE5], src_q[LIM_B_A_SE3], src_q[LIM_B_A_SE1]},
                     lvl_q[LIM_B_A_ATT],
                     lvl_q[LIM_A_GAIN_LSB +: 3]);
        b_d = mix_of(src_q[LIM_B_B_DIFF],
                     {src_q[LIM_B_B_SE6], src_q[LIM_B_B_SE4], src_q[LIM_B_B_SE2]},
                     lvl_q[LIM_B_B_ATT],
                     lvl_q[LIM_B_GAIN_LSB +: 3]);
    end

    // registered so the analog switches see glitch-free levels
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            a_q <= mix_of(LIM_SRC_RST[LIM_B_A_DIFF], 3'h0, 1'b0, LIM_LVL_RST[LIM_A_GAIN_LSB +: 3]);
            b_q <= mix_of(LIM_SRC_RST[LIM_B_B_DIFF], 3'h0, 1'b0, LIM_LVL_RST[LIM_B_GAIN_LSB +: 3]);
        end else if (CE_I) begin
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    assign LINE_A_CTL_O = a_q;
    assign LINE_B_CTL_O = b_q;
endmodule

// ===== verification/lim_ctl_props.sv
// port assertions for the line mixer control
// assumes one clock and a synchronous reset
`timescale 1ns/10ps
module lim_ctl_props (
    // watched ports
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire lim_pkg::lim_mix_ctl_t LINE_A_CTL_O,
    input wire lim_pkg::lim_mix_ctl_t LINE_B_CTL_O
);
    import lim_pkg::*;
    // ==========================================
    // write history, two deep to match output lag
    logic [7:0] w1_q, w2_q;
    wire s_wr = CE_I && REG_WR_I && REG_ADDR_I == LIM_ADDR_SRC;
    wire l_wr = CE_I && REG_WR_I && REG_ADDR_I == LIM_ADDR_LVL;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    always_ff @(posedge MCLK_I) begin
        w1_q <= REG_WDATA_I;
        w2_q <= w1_q;
    end
    a_diff_a_route: assert property (s_wr ##1 CE_I |=>
        LINE_A_CTL_O.diff_en == w2_q[7]) else $error("diff a");
    a_diff_b_route: assert property (s_wr ##1 CE_I |=>
        LINE_B_CTL_O.diff_en == w2_q[6]) else $error("diff b");
    a_se_a_pins: assert property (s_wr ##1 CE_I |=> LINE_A_CTL_O.se_en ==
        (w2_q[7] ? 3'h0 : {w2_q[1], w2_q[3], w2_q[5]})) else $error("se a");
    a_se_b_pins: assert property (s_wr ##1 CE_I |=> LINE_B_CTL_O.se_en ==
        (w2_q[6] ? 3'h0 : {w2_q[0], w2_q[2], w2_q[4]})) else $error("se b");
    a_gain_a_code: assert property (l_wr ##1 CE_I |=> LINE_A_CTL_O.gain ==
        (w2_q[5:3] > 3'h4 ? 3'h5 : w2_q[5:3])) else $error("gain a");
    a_gain_b_code: assert property (l_wr ##1 CE_I |=> LINE_B_CTL_O.gain ==
        (w2_q[2:0] > 3'h4 ? 3'h5 : w2_q[2:0])) else $error("gain b");
    a_atten_a_two: assert property (LINE_A_CTL_O.atten_6db |->
        !LINE_A_CTL_O.diff_en && $countones(LINE_A_CTL_O.se_en) > 1) else $error("att a");
    a_atten_b_two: assert property (LINE_B_CTL_O.atten_6db |->
        !LINE_B_CTL_O.diff_en && $countones(LINE_B_CTL_O.se_en) > 1) else $error("att b");
endmodule
bind lim_line_mixer_ctl lim_ctl_props lim_ctl_props_i (.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I),
    .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .LINE_A_CTL_O(LINE_A_CTL_O), .LINE_B_CTL_O(LINE_B_CTL_O));

// ===== verification/tb_top.sv
// self-checking bench for the line mixer control
// assumes only the design package and module
`timescale 1ns/10ps
module tb_top;
    import lim_pkg::*;
    // ==========================================
    // stimulus and expected outputs
    logic mclk = 0, rst = 1, ce = 1, we = 0;
    logic [7:0] addr = 0, wd = 0, rdata;
    lim_mix_ctl_t ca, cb;
    int n_fail = 0, tests_run = 0;
    logic [7:0] v [5][4] = '{'{8'ha0, 8'hc0, 8'h80, 8'h00}, '{8'h2a, 8'h88, 8'h79, 8'h00},
        '{8'h54, 8'h55, 8'h02, 8'h85}, '{8'h06, 8'hff, 8'h45, 8'h25}, '{8'h11, 8'h64, 8'h04, 8'h5c}};
    always #5 mclk = ~mclk;
    lim_line_mixer_ctl lim_line_mixer_ctl_i (.MCLK_I(mclk), .RST_I(rst), .CE_I(ce), .REG_WR_I(we),
        .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .LINE_A_CTL_O(ca), .LINE_B_CTL_O(cb));
    task chk(input logic [7:0] g, e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // strobe stays up so writes can run back to back
    task wr(input logic [7:0] a, d);
        we = 1; addr = a; wd = d;
        @(negedge mclk);
    endtask
    task rd(input logic [7:0] a, e);
        addr = a;
        #1 chk(rdata, e);
        @(negedge mclk);
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst = 0;
        rd(LIM_ADDR_SRC, 8'h00);
        rd(LIM_ADDR_LVL, 8'h1b);
        chk(ca, 8'h03);
        chk(cb, 8'h03);
        for (int i = 0; i < 5; i++) begin
            wr(LIM_ADDR_SRC, v[i][0]);
            wr(LIM_ADDR_LVL, v[i][1]);
            we = 0;
            repeat (2) @(negedge mclk);
            rd(LIM_ADDR_SRC, v[i][0]);
            rd(LIM_ADDR_LVL, v[i][1]);
            chk(ca, v[i][2]);
            chk(cb, v[i][3]);
        end
        ce = 0;
        wr(LIM_ADDR_SRC, 8'h00);
        we = 0; ce = 1;
        rd(LIM_ADDR_SRC, 8'h11);
        wr(8'h0f, 8'hff);
        we = 0;
        rd(8'h0f, 8'h00);
        rd(LIM_ADDR_LVL, 8'h64);
        tally_and_finish;
    end
    initial begin
        #5000;
        n_fail++;
        tally_and_finish;
    end
endmodule
